// ==== adc_core_calibration_sequencer.v ====
`timescale 1ns/1ns
`include "cal_seq_regs.vh"
module adc_core_calibration_sequencer #(
  parameter DW = 12,
  parameter OW = 8,
  parameter CORE_CAL = `CORE_CAL_CYCLES,
  parameter OFS_CAL = `OFS_CAL_CYCLES,
  parameter SLEEP_UNIT = `SLEEP_UNIT_CYCLES
) (
  input wire clk, // Sampling-domain clock
  input wire reset, // Sync reset, active high
  input wire calibration_pin_trigger, // Trigger pin, asynchronous
  input wire reg_we, // Register write strobe
  input wire reg_re, // Register read strobe
  input wire [14:0] reg_addr, // Register address
  input wire [7:0] reg_wdata, // Register write data
  output reg [7:0] reg_rdata_r, // Register read data
  input wire [4*DW-1:0] adc_data_in, // Converted data, four channels
  input wire [OW-1:0] ofs_estimate, // Offset estimate from measurement
  output reg [4*DW-1:0] adc_data_out_r, // Output data, four channels
  output reg calibration_status_pin, // Status pin
  output reg [5:0] core_power_r, // Core power enables, cores 0..5
  output reg [5:0] core_active_r, // Cores feeding outputs
  output reg [5:0] core_cal_r, // Core under calibration
  output reg [7:0] data_source_switch_delay, // Source switch delay
  output reg [7:0] swap_mux_select_delay // Mux select delay
);
  localparam S_IDLE = 3'd0;
  localparam S_FG = 3'd1;
  localparam S_FG_OS = 3'd2;
  localparam S_SLEEP = 3'd3;
  localparam S_WAKE = 3'd4;
  localparam S_BGCAL = 3'd5;
  localparam S_HOLD = 3'd6;

  reg [7:0] ctrl_r;
  reg [7:0] cfg_r;
  reg [7:0] spare_sleep_delay;
  reg [7:0] spare_wake_delay;
  reg [2:0] state_r;
  reg [23:0] cnt_r;
  reg [1:0] pos_r;
  reg foreground_done_flag_r;
  reg calibration_stopped_flag;
  reg trig_s1, trig_s2, trig_s3, trig_pin_r;
  reg trig_d_r;
  reg [2:0] ofs_core_r;
  reg ofs_we_r;
  reg [2:0] ofs_wr_core_r;
  wire [OW*6-1:0] trims;
  wire background_cal_enable = ctrl_r[`CTRL_BG_EN];
  wire foreground_offset_enable = ctrl_r[`CTRL_FG_OS];
  wire background_offset_enable = ctrl_r[`CTRL_BG_OS];
  wire low_power_bg_enable = ctrl_r[`CTRL_LOW_POWER_BG_ENABLE];
  wire manual_trigger_select = ctrl_r[`CTRL_LP_MANUAL];
  wire spare_offset_reference = cfg_r[`CFG_OS_REF];
  // Source-selected trigger level
  wire trig = ctrl_r[`CTRL_TRIG_SRC] ? trig_pin_r : ctrl_r[`CTRL_SOFT_TRIG];
  wire trig_rise = trig & ~trig_d_r;
  wire lp_manual = low_power_bg_enable & manual_trigger_select;
  // Spare is the idle core of group 0,1,2 (pos 0,1) or 3,4,5 (pos 2,3)
  wire [2:0] spare_core = pos_r[1] ? (!core_active_r[3] ? 3'd3 : !core_active_r[4] ? 3'd4 : 3'd5) :
    (!core_active_r[2] ? 3'd2 : !core_active_r[0] ? 3'd0 : 3'd1);
  // Spare relieves the next core in rotation, so every core gets its turn
  wire [2:0] out_core = (spare_core == 3'd2) ? 3'd0 : (spare_core == 3'd0) ? 3'd1 : (spare_core == 3'd1) ? 3'd2 :
    (spare_core == 3'd3) ? 3'd4 : (spare_core == 3'd4) ? 3'd5 : 3'd3;
  wire [5:0] spare_mask = 6'b000001 << spare_core;
  wire [5:0] out_mask = 6'b000001 << out_core;
  wire [31:0] sleep_prod = spare_sleep_delay * SLEEP_UNIT;
  wire [23:0] sleep_cycles = sleep_prod[23:0];
  wire [23:0] wake_cycles = {16'h0000, spare_wake_delay} + 24'h000001;

  // Three-stage input synchroniser
  always @(posedge clk) begin
    if (reset) begin
      trig_s1 <= 1'b0;
      trig_s2 <= 1'b0;
      trig_s3 <= 1'b0;
      trig_pin_r <= 1'b0;
    end else begin
      trig_s1 <= calibration_pin_trigger;
      trig_s2 <= trig_s1;
      trig_s3 <= trig_s2;
      if (trig_s2 == trig_s3) begin
        trig_pin_r <= trig_s3;
      end
    end
  end

  // Register writes; software trim writes are blocked only in the cycle of a calibration trim update
  always @(posedge clk) begin
    if (reset) begin
      ctrl_r <= `CTRL_RESET;
      cfg_r <= `CFG_RESET;
      spare_sleep_delay <= `SLEEP_RESET;
      spare_wake_delay <= `WAKE_RESET;
      data_source_switch_delay <= `SRC_DLY_RESET;
      swap_mux_select_delay <= `MUX_DLY_RESET;
    end else if (reg_we) begin
      if (reg_addr == `ADDR_CAL_CTRL) begin
        ctrl_r <= reg_wdata;
      end else if (reg_addr == `ADDR_CAL_CFG) begin
        cfg_r <= reg_wdata;
      end else if (reg_addr == `ADDR_LP_SLEEP) begin
        spare_sleep_delay <= reg_wdata;
      end else if (reg_addr == `ADDR_LP_WAKE) begin
        spare_wake_delay <= reg_wdata;
      end else if (reg_addr == `ADDR_SRC_SWITCH_DLY) begin
        data_source_switch_delay <= reg_wdata;
      end else if (reg_addr == `ADDR_SWAP_MUX_SELECT_DELAY) begin
        swap_mux_select_delay <= reg_wdata;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1) begin : trim_g
      core_offset_trim #(.W(OW)) u_trim (
        .clk(clk),
        .reset(reset),
        .sw_we(reg_we & (reg_addr == `ADDR_OFS_BASE + g) & ~ofs_we_r),
        .cal_we(ofs_we_r & (ofs_wr_core_r == g)),
        .sw_data(reg_wdata),
        .cal_data(ofs_estimate),
        .trim_r(trims[g*OW +: OW])
      );
    end
  endgenerate

  // Read mux
  always @(posedge clk) begin
    if (reset) begin
      reg_rdata_r <= 8'h00;
    end else if (reg_re) begin
      if (reg_addr == `ADDR_CAL_CTRL) begin
        reg_rdata_r <= ctrl_r;
      end else if (reg_addr == `ADDR_CAL_CFG) begin
        reg_rdata_r <= cfg_r;
      end else if (reg_addr == `ADDR_LP_SLEEP) begin
        reg_rdata_r <= spare_sleep_delay;
      end else if (reg_addr == `ADDR_LP_WAKE) begin
        reg_rdata_r <= spare_wake_delay;
      end else if (reg_addr == `ADDR_SRC_SWITCH_DLY) begin
        reg_rdata_r <= data_source_switch_delay;
      end else if (reg_addr == `ADDR_SWAP_MUX_SELECT_DELAY) begin
        reg_rdata_r <= swap_mux_select_delay;
      end else if (reg_addr == `ADDR_CAL_STATUS) begin
        reg_rdata_r <= {2'b00, pos_r, calibration_stopped_flag, state_r == S_FG || state_r == S_FG_OS,
          foreground_done_flag_r, state_r != S_IDLE};
      end else if (reg_addr >= `ADDR_OFS_BASE && reg_addr < `ADDR_OFS_BASE + 15'd6) begin
        reg_rdata_r <= trims[reg_addr[2:0]*OW +: OW];
      end else begin
        reg_rdata_r <= 8'h00;
      end
    end
  end

  // Calibration sequencer
  always @(posedge clk) begin
    if (reset) begin
      state_r <= S_FG;
      cnt_r <= 24'h000000;
      pos_r <= 2'd0;
      foreground_done_flag_r <= 1'b0;
      calibration_stopped_flag <= 1'b0;
      trig_d_r <= 1'b0;
      ofs_core_r <= 3'd0;
      ofs_wr_core_r <= 3'd0;
      ofs_we_r <= 1'b0;
      core_power_r <= 6'b110011;
      core_active_r <= 6'b110011;
      core_cal_r <= 6'b000000;
    end else begin
      trig_d_r <= trig;
      ofs_we_r <= 1'b0;
      case (state_r)
        S_IDLE: begin
          core_active_r <= 6'b110011;
          core_power_r <= 6'b110011;
          core_cal_r <= 6'b000000;
          calibration_stopped_flag <= 1'b0;
          if (ctrl_r[`CTRL_CAL_EN] && !background_cal_enable && trig_rise) begin
            foreground_done_flag_r <= 1'b0;
            cnt_r <= 24'h000000;
            state_r <= S_FG;
          end else if (ctrl_r[`CTRL_CAL_EN] && background_cal_enable) begin
            foreground_done_flag_r <= 1'b0;
            cnt_r <= 24'h000000;
            state_r <= S_FG;
          end
        end
        S_FG: begin
          core_cal_r <= background_cal_enable ? 6'b111111 : 6'b110011;
          core_power_r <= background_cal_enable ? 6'b111111 : 6'b110011;
          cnt_r <= cnt_r + 24'h000001;
          if (cnt_r == CORE_CAL - 1) begin
            cnt_r <= 24'h000000;
            ofs_core_r <= 3'd0;
            state_r <= foreground_offset_enable ? S_FG_OS : S_SLEEP;
            if (!foreground_offset_enable) begin
              foreground_done_flag_r <= 1'b1;
              state_r <= background_cal_enable ? S_SLEEP : S_IDLE;
            end
          end
        end
        S_FG_OS: begin
          // Six cores with background on, else the four main cores
          cnt_r <= cnt_r + 24'h000001;
          if (cnt_r == OFS_CAL - 1) begin
            cnt_r <= 24'h000000;
            ofs_we_r <= 1'b1;
            ofs_wr_core_r <= ofs_core_r;
            if (ofs_core_r == 3'd5) begin
              foreground_done_flag_r <= 1'b1;
              state_r <= background_cal_enable ? S_SLEEP : S_IDLE;
            end else begin
              ofs_core_r <= (!background_cal_enable && ofs_core_r == 3'd1) ? 3'd4 : ofs_core_r + 3'd1;
            end
          end
        end
        S_SLEEP: begin
          core_cal_r <= 6'b000000;
          core_power_r <= low_power_bg_enable ? core_active_r : (core_active_r | spare_mask);
          calibration_stopped_flag <= 1'b0;
          cnt_r <= cnt_r + 24'h000001;
          if (!background_cal_enable) begin
            state_r <= S_IDLE;
          end else if (!low_power_bg_enable) begin
            cnt_r <= 24'h000000;
            state_r <= S_WAKE;
          end else if (lp_manual) begin
            cnt_r <= 24'h000000;
            if (!trig) begin
              state_r <= S_WAKE;
            end
          end else if (cnt_r >= sleep_cycles) begin
            cnt_r <= 24'h000000;
            state_r <= S_WAKE;
          end
        end
        S_WAKE: begin
          core_power_r <= core_active_r | spare_mask;
          cnt_r <= cnt_r + 24'h000001;
          if (cnt_r >= wake_cycles || !low_power_bg_enable) begin
            cnt_r <= 24'h000000;
            state_r <= S_BGCAL;
          end
        end
        S_BGCAL: begin
          core_cal_r <= spare_mask;
          core_power_r <= core_active_r | spare_mask;
          cnt_r <= cnt_r + 24'h000001;
          if (cnt_r == CORE_CAL - 1) begin
            cnt_r <= 24'h000000;
            calibration_stopped_flag <= 1'b1;
            if (background_offset_enable) begin
              ofs_wr_core_r <= spare_offset_reference ? out_core : spare_core;
              ofs_we_r <= 1'b1;
            end
            state_r <= S_HOLD;
          end
        end
        S_HOLD: begin
          core_cal_r <= 6'b000000;
          if (!lp_manual || trig) begin
            core_active_r <= (core_active_r & ~out_mask) | spare_mask;
            core_power_r <= (core_active_r & ~out_mask) | spare_mask;
            pos_r <= pos_r + 2'd1;
            state_r <= S_SLEEP;
          end
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end

  // Mid-scale data during foreground cal; status pin select
  always @(posedge clk) begin
    if (reset) begin
      adc_data_out_r <= {4*DW{1'b0}};
      calibration_status_pin <= 1'b0;
    end else begin
      adc_data_out_r <= (state_r == S_FG || state_r == S_FG_OS) ? {4*DW{1'b0}} : adc_data_in;
      calibration_status_pin <= cfg_r[`CFG_STAT_SEL] ? calibration_stopped_flag : foreground_done_flag_r;
    end
  end
endmodule

// ==== cal_seq_regs.vh ====
`ifndef CAL_SEQ_REGS_VH
`define CAL_SEQ_REGS_VH
// Register addresses
`define ADDR_SRC_SWITCH_DLY 15'h009a
`define ADDR_SWAP_MUX_SELECT_DELAY 15'h009b
`define ADDR_CAL_CTRL 15'h0060
`define ADDR_CAL_CFG 15'h0061
`define ADDR_LP_SLEEP 15'h0062
`define ADDR_LP_WAKE 15'h0063
`define ADDR_CAL_STATUS 15'h0064
`define ADDR_OFS_BASE 15'h0070
// Control register bit positions
`define CTRL_CAL_EN 0
`define CTRL_SOFT_TRIG 1
`define CTRL_TRIG_SRC 2
`define CTRL_BG_EN 3
`define CTRL_FG_OS 4
`define CTRL_BG_OS 5
`define CTRL_LOW_POWER_BG_ENABLE 6
`define CTRL_LP_MANUAL 7
// Config register bit positions
`define CFG_STAT_SEL 0
`define CFG_OS_REF 1
// Reset values
`define CTRL_RESET 8'h01
`define CFG_RESET 8'h00
`define SRC_DLY_RESET 8'h00
`define MUX_DLY_RESET 8'h00
`define SLEEP_RESET 8'h10
`define WAKE_RESET 8'h04
// Timing counts in clock cycles
`define CORE_CAL_CYCLES 16'h0100
`define OFS_CAL_CYCLES 16'h0040
`define SLEEP_UNIT_CYCLES 16'h0100
`endif

// ==== core_offset_trim.v ====
`timescale 1ns/1ns
// One core's offset trim: software write, calibration update
module core_offset_trim #(
  parameter W = 8
) (
  input wire clk, // Clock
  input wire reset, // Sync reset, active high
  input wire sw_we, // Software write strobe
  input wire cal_we, // Calibration update strobe
  input wire [W-1:0] sw_data, // Software data
  input wire [W-1:0] cal_data, // Calibration data
  output reg [W-1:0] trim_r // Trim value
);
  always @(posedge clk) begin
    if (reset) begin
      trim_r <= {W{1'b0}};
    end else if (cal_we) begin
      trim_r <= cal_data;
    end else if (sw_we) begin
      trim_r <= sw_data;
    end
  end
endmodule

// ==== adc_core_calibration_sequencer_monitor.sv ====
`timescale 1ns/1ns
`include "cal_seq_regs.vh"
module adc_core_calibration_sequencer_monitor #(
  parameter DW = 12
) (
  input wire clk, // Clock
  input wire reset, // Reset
  input wire reg_we, // Write strobe
  input wire reg_re, // Read strobe
  input wire [14:0] reg_addr, // Address
  input wire [7:0] reg_wdata, // Write data
  input wire [7:0] reg_rdata_r, // Read data
  input wire [4*DW-1:0] adc_data_in, // Data in
  input wire [4*DW-1:0] adc_data_out_r, // Data out
  input wire [5:0] core_power_r, // Powered cores
  input wire [5:0] core_active_r, // Active cores
  input wire [5:0] core_cal_r, // Core in cal
  input wire [7:0] data_source_switch_delay, // Src delay
  input wire [7:0] swap_mux_select_delay // Mux delay
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_one_core_cal: assert property ((core_cal_r & core_active_r) == 6'h00 |-> $onehot0(core_cal_r))
    else $error("two cores in cal");
  a_four_active: assert property ($countones(core_active_r) == 4) else $error("active count");
  a_spare_pairs: assert property ($countones(core_active_r[2:0]) == 2) else $error("bad pair swap");
  a_cal_offline: assert property ($onehot(core_cal_r) |-> (core_cal_r & core_active_r) == 6'h00)
    else $error("cal core active");
  a_fg_mid_code: assert property ((core_cal_r & core_active_r) != 6'h00 |-> adc_data_out_r == 0)
    else $error("data not mid-scale in foreground cal");
  a_cal_powered: assert property ((core_cal_r & ~core_power_r) == 6'h00) else $error("cal core off");
  a_active_pwr: assert property ((core_active_r & ~core_power_r) == 6'h00) else $error("active core off");
  a_data_mid: assert property (adc_data_out_r == 0 || adc_data_out_r == $past(adc_data_in))
    else $error("data out");
  a_src_dly_wr: assert property (reg_we && reg_addr == `ADDR_SRC_SWITCH_DLY |=>
    data_source_switch_delay == $past(reg_wdata)) else $error("src delay");
  a_mux_dly_wr: assert property (reg_we && reg_addr == `ADDR_SWAP_MUX_SELECT_DELAY |=>
    swap_mux_select_delay == $past(reg_wdata)) else $error("mux delay");
  a_rdata_hold: assert property (!reg_re |=> $stable(reg_rdata_r)) else $error("rdata moved");
endmodule
bind adc_core_calibration_sequencer adc_core_calibration_sequencer_monitor #(.DW(DW)) i_mon (.clk(clk),
  .reset(reset), .reg_we(reg_we), .reg_re(reg_re), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata_r(reg_rdata_r), .adc_data_in(adc_data_in), .adc_data_out_r(adc_data_out_r),
  .core_power_r(core_power_r), .core_active_r(core_active_r), .core_cal_r(core_cal_r),
  .data_source_switch_delay(data_source_switch_delay), .swap_mux_select_delay(swap_mux_select_delay));

// ==== cal_controller_model.sv ====
`timescale 1ns/1ns
module cal_controller_model (
  input wire clk, // Clock
  input wire calibration_status_pin, // Status from device
  output reg calibration_pin_trigger // Trigger to device
);
  initial calibration_pin_trigger = 1'b0;
  task wait_status(input lvl, output ok);
    integer k;
    begin
      ok = 1'b0;
      for (k = 0; k < 3000 && !ok; k = k + 1) begin
        @(negedge clk);
        ok = (calibration_status_pin === lvl);
      end
    end
  endtask
  // Hold the pin until the start shows on status
  task pin_trigger(output ok);
    begin
      @(negedge clk);
      calibration_pin_trigger = 1'b1;
      wait_status(1'b0, ok);
      calibration_pin_trigger = 1'b0;
    end
  endtask
endmodule

// ==== adc_core_calibration_sequencer_tb_top.sv ====
`timescale 1ns/1ns
`include "cal_seq_regs.vh"
module adc_core_calibration_sequencer_tb_top;
  reg clk = 1'b0;
  reg reset = 1'b1;
  reg reg_we = 1'b0;
  reg reg_re = 1'b0;
  reg [14:0] reg_addr = 15'h0000;
  reg [7:0] reg_wdata = 8'h00;
  reg [47:0] adc_data_in = 48'h123456789abc;
  reg [7:0] ofs_estimate = 8'h5a;
  wire [7:0] reg_rdata_r, src_dly, mux_dly;
  wire [47:0] adc_data_out_r;
  wire calibration_status_pin, calibration_pin_trigger;
  wire [5:0] core_power_r, core_active_r, core_cal_r;
  integer n_fail = 0;
  integer n_tests = 0;
  integer i;
  reg [7:0] rd;
  reg [5:0] act;
  reg ok;
  reg [30:0] rows [0:6];
  always #5 clk = ~clk;
  adc_core_calibration_sequencer #(.CORE_CAL(8), .OFS_CAL(4), .SLEEP_UNIT(4)) i_adc_core_calibration_sequencer (
    .clk(clk), .reset(reset), .calibration_pin_trigger(calibration_pin_trigger), .reg_we(reg_we),
    .reg_re(reg_re), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r),
    .adc_data_in(adc_data_in), .ofs_estimate(ofs_estimate), .adc_data_out_r(adc_data_out_r),
    .calibration_status_pin(calibration_status_pin), .core_power_r(core_power_r),
    .core_active_r(core_active_r), .core_cal_r(core_cal_r), .data_source_switch_delay(src_dly),
    .swap_mux_select_delay(mux_dly));
  cal_controller_model i_cal_controller_model (.clk(clk), .calibration_status_pin(calibration_status_pin),
    .calibration_pin_trigger(calibration_pin_trigger));
  task end_of_test;
    begin
      if (n_fail == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask
  task chk(input [47:0] seen, input [47:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task wr(input [14:0] a, input [7:0] d);
    begin
      @(negedge clk);
      reg_we = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge clk);
      reg_we = 1'b0;
    end
  endtask
  task rdr(input [14:0] a);
    begin
      @(negedge clk);
      reg_re = 1'b1;
      reg_addr = a;
      @(negedge clk);
      reg_re = 1'b0;
      rd = reg_rdata_r;
    end
  endtask
  task st(input lvl);
    begin
      i_cal_controller_model.wait_status(lvl, ok);
      if (!ok) begin n_fail = n_fail + 1; end_of_test; end
    end
  endtask
  task wait_on(input integer sel);
    integer k;
    reg c;
    begin
      c = 1'b0;
      for (k = 0; k < 3000 && !c; k = k + 1) begin
        @(negedge clk);
        case (sel)
          0: c = (core_cal_r !== 6'h00);
          1: c = (core_cal_r === 6'h00);
          2: c = (core_active_r !== act);
          default: c = ((core_power_r & ~core_active_r) === 6'h00);
        endcase
      end
      if (!c) begin n_fail = n_fail + 1; end_of_test; end
    end
  endtask
  initial begin
    rows[0] = {`ADDR_CAL_CTRL, 8'h00, `CTRL_RESET};
    rows[1] = {`ADDR_CAL_CFG, 8'h00, `CFG_RESET};
    rows[2] = {`ADDR_LP_SLEEP, 8'h08, `SLEEP_RESET};
    rows[3] = {`ADDR_LP_WAKE, 8'h02, `WAKE_RESET};
    rows[4] = {`ADDR_SRC_SWITCH_DLY, 8'h1f, `SRC_DLY_RESET};
    rows[5] = {`ADDR_SWAP_MUX_SELECT_DELAY, 8'h1e, `MUX_DLY_RESET};
    rows[6] = {15'h0050, 8'h55, 8'h00};
    repeat (20) @(negedge clk);
    chk(core_active_r, 6'h33);
    chk(core_power_r, 6'h33);
    reset = 1'b0;
    repeat (3) @(negedge clk);
    chk(adc_data_out_r, 48'h0);
    st(1'b1);
    @(negedge clk);
    chk(adc_data_out_r, adc_data_in);
    rdr(`ADDR_CAL_STATUS);
    chk(rd[1], 1'b1);
    for (i = 0; i < 7; i = i + 1) begin
      rdr(rows[i][30:16]);
      chk(rd, rows[i][7:0]);
      if (i > 1) wr(rows[i][30:16], rows[i][15:8]);
      if (i > 1) rdr(rows[i][30:16]);
      if (i > 1) chk(rd, (i == 6) ? 8'h00 : rows[i][15:8]);
    end
    chk({src_dly, mux_dly}, 16'h1f1e);
    wr(`ADDR_CAL_CTRL, 8'h05);
    wr(`ADDR_CAL_CTRL, 8'h07);
    repeat (20) @(negedge clk);
    chk(calibration_status_pin, 1'b1);
    i_cal_controller_model.pin_trigger(ok);
    chk(ok, 1'b1);
    chk(adc_data_out_r, 48'h0);
    st(1'b1);
    wr(`ADDR_CAL_CTRL, 8'h11);
    wr(`ADDR_CAL_CTRL, 8'h13);
    st(1'b0);
    st(1'b1);
    rdr(`ADDR_OFS_BASE);
    chk(rd, 8'h5a);
    rdr(`ADDR_OFS_BASE + 15'h0005);
    chk(rd, 8'h5a);
    ofs_estimate = 8'h3c;
    wr(`ADDR_CAL_CTRL, 8'h19);
    wr(`ADDR_CAL_CTRL, 8'h1b);
    st(1'b0);
    st(1'b1);
    rdr(`ADDR_OFS_BASE + 15'h0002);
    chk(rd, 8'h3c);
    rdr(`ADDR_OFS_BASE + 15'h0003);
    chk(rd, 8'h3c);
    act = core_active_r;
    wait_on(0);
    wait_on(2);
    chk(core_active_r, 6'h36);
    wr(`ADDR_CAL_CFG, 8'h01);
    wr(`ADDR_CAL_CTRL, 8'hcb);
    wait_on(3);
    repeat (50) @(negedge clk);
    chk(core_power_r & ~core_active_r, 6'h00);
    chk(core_cal_r, 6'h00);
    wr(`ADDR_CAL_CTRL, 8'hc9);
    wait_on(0);
    wait_on(1);
    act = core_active_r;
    repeat (3) @(negedge clk);
    chk(calibration_status_pin, 1'b1);
    repeat (20) @(negedge clk);
    chk(core_active_r, act);
    chk((core_power_r & ~core_active_r) != 6'h00, 1'b1);
    wr(`ADDR_CAL_CTRL, 8'hcb);
    wait_on(2);
    // Automatic low-power cycle with background offset on
    act = core_active_r;
    ofs_estimate = 8'h77;
    wr(`ADDR_CAL_CTRL, 8'h6b);
    wait_on(0);
    wait_on(1);
    chk(core_active_r == act, 1'b0);
    for (i = 0; i < 200 && (core_power_r & ~core_active_r) === 6'h00; i = i + 1) begin
      @(negedge clk);
    end
    // Sleep of 8 units of 4 cycles, plus state hops
    chk(i >= 32 && i <= 36, 1'b1);
    wr(`ADDR_CAL_CFG, 8'h03);
    ofs_estimate = 8'h99;
    wait_on(0);
    wait_on(1);
    wr(`ADDR_CAL_CTRL, 8'h4b);
    rdr(`ADDR_OFS_BASE + 15'h0002);
    chk(rd, 8'h99);
    rdr(`ADDR_OFS_BASE + 15'h0001);
    chk(rd, 8'h3c);
    rdr(`ADDR_OFS_BASE + 15'h0004);
    chk(rd, 8'h77);
    // Mid-run reset reruns the power-up calibration
    reset = 1'b1;
    repeat (2) @(negedge clk);
    chk(core_active_r, 6'h33);
    reset = 1'b0;
    repeat (3) @(negedge clk);
    chk(adc_data_out_r, 48'h0);
    st(1'b1);
    end_of_test;
  end
endmodule
